// >>> test/test_servo_motion_parameter_regs.sv
// self-checking testbench for the motion parameter register bank
`timescale 1ns/1ps
module test_servo_motion_parameter_regs
  import motion_regs_pkg::*;
;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, sample_tick, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, encoder_count, rd;
  logic [31:0] accel_out, load_ratio_out, target_pos_out, actual_pos_out;
  logic [9:0]  torque_cap;
  zero_event_t zero_event;
  int          err_total, cmp_count, n;

  // short sample period keeps the run small
  motion_param_regs #(.PERIOD_CYCLES(8)) dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_count(encoder_count), .zero_event(zero_event),
    .accel_out(accel_out), .torque_cap(torque_cap), .load_ratio_out(load_ratio_out),
    .target_pos_out(target_pos_out), .actual_pos_out(actual_pos_out),
    .sample_tick(sample_tick)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    // the write lands at the ready edge; its outputs are settled one edge later
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sample_tick !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic t_reset;
    rchk(IDX_ACCEL, 32'h0000_0012);
    rchk(IDX_TORQUE, 32'h0000_03FF);
    rchk(IDX_LOAD_RATIO, 32'h0001_0000);
    rchk(IDX_ACT_POS, 32'h0000_0000);
    rchk(IDX_AVG_VEL, 32'h0000_0000);
    rchk(IDX_INST_VEL, 32'h0000_0000);
    chk({22'h0, torque_cap}, 32'h0000_03FF);
  endtask

  task automatic t_rw;
    wr(IDX_ACCEL, 32'h0000_0168);
    rchk(IDX_ACCEL, 32'h0000_0168);
    chk(accel_out, 32'h0000_0168);
    wr(IDX_TORQUE, 32'h0000_0155);
    chk({22'h0, torque_cap}, 32'h0000_0155);
    wr(IDX_TORQUE, 32'h0000_07FF);
    rchk(IDX_TORQUE, 32'h0000_03FF);
    wr(IDX_LOAD_RATIO, 32'h0002_8000);
    chk(load_ratio_out, 32'h0002_8000);
    wr(IDX_LOAD_RATIO, 32'h0001_0000);
    rchk(IDX_LOAD_RATIO, 32'h0001_0000);
    wr(IDX_FUNC_POS, 32'hDEAD_BEEF);
    rchk(IDX_FUNC_POS, 32'hDEAD_BEEF);
  endtask

  task automatic t_refused;
    wr(IDX_AVG_VEL, 32'h0000_1234);
    rchk(IDX_AVG_VEL, 32'h0000_0000);
    wr(IDX_INST_VEL, 32'hFFFF_FFFF);
    rchk(IDX_INST_VEL, 32'h0000_0000);
    rchk(8'h3F, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
  endtask

  task automatic t_atomic;
    wr(IDX_NEW_POS, 32'h0000_0050);
    wr(IDX_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk(actual_pos_out, 32'h0000_0050);
    chk(target_pos_out, 32'h0000_0050);
    wr(IDX_NEW_POS, 32'hFFFF_FFF0);
    wr(IDX_CTRL, 32'h0000_0006);
    repeat (3) @(posedge clk);
    chk(actual_pos_out, 32'h0000_0040);
    rchk(IDX_TARGET_POS, 32'h0000_0040);
  endtask

  // new base, then one encoder step of 16 counts crosses one sample
  task automatic t_incr;
    wr(IDX_ACT_POS, 32'h0000_0100);
    wait_tick();
    encoder_count <= encoder_count + 32'h0000_0010;
    wait_tick();
    repeat (2) @(posedge clk);
    chk(actual_pos_out, 32'h0000_0110);
    rchk(IDX_INST_VEL, 32'h0000_0010);
    rchk(IDX_AVG_VEL, 32'h0000_0001);
  endtask

  task automatic t_zero;
    @(posedge clk);
    zero_event <= '{1'b1, 32'h0000_4000, 32'h0000_0123};
    @(posedge clk);
    zero_event <= '{1'b0, 32'h0000_0000, 32'h0000_0000};
    rchk(IDX_ZERO_OFS, 32'h0000_0123);
    rchk(IDX_ACT_POS, 32'h0000_4000);
  endtask

  task automatic t_divider;
    wait_tick();
    wait_tick();
    chk(n, 32'h0000_0008);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_tick();
    wait_tick();
    chk(n, 32'h0000_0010);
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    err_total++;
    finish_test();
  end

  initial begin
    err_total     = 0;
    cmp_count     = 0;
    resetn        = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 12'h000;
    pwdata        = 32'h0000_0000;
    encoder_count = 32'h0000_0000;
    zero_event    = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rw();
    t_refused();
    t_atomic();
    t_incr();
    t_zero();
    t_divider();
    finish_test();
  end
endmodule // test_servo_motion_parameter_regs

// >>> verilog/motion_param_regs.sv
// apb register bank for servo motion parameters
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module motion_param_regs
  import motion_regs_pkg::*;
#(
  parameter int PERIOD_CYCLES = PERIOD_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] encoder_count,
  input  wire zero_event_t zero_event,
  output logic      [31:0] accel_out,
  output logic      [9:0]  torque_cap,
  output logic      [31:0] load_ratio_out,
  output logic      [31:0] target_pos_out,
  output logic      [31:0] actual_pos_out,
  output logic             sample_tick
);
  logic [31:0] accel_q, accel_d, torque_q, torque_d, fpos_q, fpos_d, zofs_q, zofs_d;
  logic [31:0] apos_q, apos_d, ratio_q, ratio_d, newp_q, newp_d, tgt_q, tgt_d;
  logic [31:0] enc_q, enc_d, delta_q, delta_d, prdata_q, prdata_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic [31:0] cnt_q, cnt_d;
  logic        tick_q, tick_d, pready_q, pready_d, pslverr_q, pslverr_d;
  logic        vel_tick_q, vel_tick_d;
  logic [31:0] inst_vel, avg_vel;
  logic        wr, rd;
  logic [7:0]  idx;

  function automatic logic mapped(input logic [7:0] i);
    return (i >= IDX_ACCEL && i <= IDX_LOAD_RATIO) || i == IDX_NEW_POS ||
           i == IDX_CTRL || i == IDX_TARGET_POS;
  endfunction

  assign idx = paddr[9:2];
  // a write lands only at the edge where the master sees ready high
  assign wr  = psel && penable && pwrite && pready_q;
  assign rd  = psel && !penable;

  // one wait state: ready raised on the second access cycle
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !mapped(idx);
    prdata_d  = prdata_q;
    if (rd) begin
      case (idx)
        IDX_ACCEL:      prdata_d = accel_q;
        IDX_TORQUE:     prdata_d = torque_q;
        IDX_FUNC_POS:   prdata_d = fpos_q;
        IDX_ZERO_OFS:   prdata_d = zofs_q;
        IDX_ACT_POS:    prdata_d = apos_q;
        IDX_AVG_VEL:    prdata_d = avg_vel;
        IDX_INST_VEL:   prdata_d = inst_vel;
        IDX_LOAD_RATIO: prdata_d = ratio_q;
        IDX_NEW_POS:    prdata_d = newp_q;
        IDX_CTRL:       prdata_d = {29'h0, ctrl_q};
        IDX_TARGET_POS: prdata_d = tgt_q;
        default:        prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // sample period timer
  always_comb begin
    tick_d = 1'b0;
    vel_tick_d = tick_q;
    cnt_d  = cnt_q + 32'h0000_0001;
    // divider 2 doubles the period
    if (cnt_q >= (ctrl_q[CTRL_DIV2_BIT] ? 32'(2*PERIOD_CYCLES - 1) : 32'(PERIOD_CYCLES - 1))) begin // RULE_05
      cnt_d  = 32'h0000_0000;
      tick_d = 1'b1;
    end
  end

  always_comb begin
    accel_d = accel_q;
    torque_d = torque_q;
    fpos_d  = fpos_q;
    zofs_d  = zofs_q;
    apos_d  = apos_q;
    ratio_d = ratio_q;
    newp_d  = newp_q;
    tgt_d   = tgt_q;
    ctrl_d  = ctrl_q;
    ctrl_d[CTRL_GO_BIT] = 1'b0;
    enc_d   = enc_q;
    delta_d = delta_q;
    if (tick_q) begin
      // counter advances by encoder delta, so host offsets persist
      delta_d = encoder_count - enc_q; // RULE_06
      enc_d   = encoder_count;
      apos_d  = apos_q + (encoder_count - enc_q); // RULE_05
    end
    if (wr) begin
      case (idx)
        IDX_ACCEL:      accel_d = pwdata; // RULE_01
        // values above 1023 saturate to the 300 percent peak
        IDX_TORQUE:     torque_d = (pwdata > TORQUE_MAX) ? TORQUE_MAX : pwdata; // RULE_02 RULE_03
        IDX_FUNC_POS:   fpos_d  = pwdata;
        IDX_ZERO_OFS:   zofs_d  = pwdata;
        IDX_ACT_POS:    apos_d  = pwdata; // RULE_06
        IDX_LOAD_RATIO: ratio_d = pwdata; // RULE_11
        IDX_NEW_POS:    newp_d  = pwdata;
        IDX_CTRL:       ctrl_d  = pwdata[2:0];
        IDX_TARGET_POS: tgt_d   = pwdata;
        default:        ; // RULE_14
      endcase
    end
    if (ctrl_q[CTRL_GO_BIT]) begin
      if (ctrl_q[CTRL_REL_BIT]) begin
        apos_d = apos_d + newp_q; // RULE_13
        tgt_d  = tgt_q + newp_q;
        fpos_d = fpos_q + newp_q;
      end else begin
        apos_d = newp_q; // RULE_13
        tgt_d  = newp_q;
        fpos_d = newp_q;
      end
    end
    if (zero_event.valid) begin
      zofs_d = zero_event.single_turn; // RULE_04
      apos_d = zero_event.position; // RULE_08
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accel_q  <= RST_ACCEL;
      torque_q <= RST_TORQUE;
      fpos_q   <= RST_ZERO;
      zofs_q   <= RST_ZERO;
      apos_q   <= RST_ZERO;
      ratio_q  <= RST_LOAD_RATIO;
      newp_q   <= RST_ZERO;
      tgt_q    <= RST_ZERO;
      ctrl_q   <= 3'h0;
      enc_q    <= RST_ZERO;
      delta_q  <= RST_ZERO;
      cnt_q    <= 32'h0000_0000;
      tick_q   <= 1'b0;
      vel_tick_q <= 1'b0;
      prdata_q <= RST_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      accel_q  <= accel_d;
      torque_q <= torque_d;
      fpos_q   <= fpos_d;
      zofs_q   <= zofs_d;
      apos_q   <= apos_d;
      ratio_q  <= ratio_d;
      newp_q   <= newp_d;
      tgt_q    <= tgt_d;
      ctrl_q   <= ctrl_d;
      enc_q    <= enc_d;
      delta_q  <= delta_d;
      cnt_q    <= cnt_d;
      tick_q   <= tick_d;
      vel_tick_q <= vel_tick_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // velocities sampled one cycle after the position refresh
  velocity_sampler u_vel (
    .clk      (clk),
    .resetn   (resetn),
    .sample   (vel_tick_q),
    .delta    (delta_q),
    .inst_vel (inst_vel),
    .avg_vel  (avg_vel)
  );

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign accel_out      = accel_q;
  assign torque_cap     = torque_q[9:0];
  assign load_ratio_out = ratio_q;
  assign target_pos_out = tgt_q;
  assign actual_pos_out = apos_q;
  assign sample_tick    = tick_q;

  property p_torque_cap;
    @(posedge clk) disable iff (!resetn) torque_q <= TORQUE_MAX;
  endproperty
  a_torque_cap: assert property (p_torque_cap) else $error("torque above 1023"); // RULE_02
  property p_torque_sat;
    @(posedge clk) disable iff (!resetn)
      wr && idx == IDX_TORQUE && pwdata > TORQUE_MAX && !ctrl_q[CTRL_GO_BIT]
      |=> torque_q == TORQUE_MAX;
  endproperty
  a_torque_sat: assert property (p_torque_sat) else $error("torque not saturated"); // RULE_03
  property p_accel_wr;
    @(posedge clk) disable iff (!resetn) wr && idx == IDX_ACCEL |=> accel_q == $past(pwdata);
  endproperty
  a_accel_wr: assert property (p_accel_wr) else $error("accel write lost"); // RULE_01
  property p_zero_ofs;
    @(posedge clk) disable iff (!resetn)
      zero_event.valid |=> zofs_q == $past(zero_event.single_turn);
  endproperty
  a_zero_ofs: assert property (p_zero_ofs) else $error("index offset not updated"); // RULE_04
  property p_zero_pos;
    @(posedge clk) disable iff (!resetn)
      zero_event.valid |=> apos_q == $past(zero_event.position);
  endproperty
  a_zero_pos: assert property (p_zero_pos) else $error("position not set by zero"); // RULE_08
  property p_period;
    @(posedge clk) disable iff (!resetn)
      tick_q && !ctrl_q[CTRL_DIV2_BIT] |=> !tick_q [*2];
  endproperty
  a_period: assert property (p_period) else $error("sample ticks too close"); // RULE_05
  property p_hold_pos;
    @(posedge clk) disable iff (!resetn)
      !tick_q && !wr && !ctrl_q[CTRL_GO_BIT] && !zero_event.valid |=> $stable(apos_q);
  endproperty
  a_hold_pos: assert property (p_hold_pos) else $error("position moved unprompted"); // RULE_06
  property p_atomic;
    @(posedge clk) disable iff (!resetn)
      ctrl_q[CTRL_GO_BIT] && !ctrl_q[CTRL_REL_BIT] && !zero_event.valid
      |=> apos_q == tgt_q;
  endproperty
  a_atomic: assert property (p_atomic) else $error("atomic update split"); // RULE_13
  property p_ratio_wr;
    @(posedge clk) disable iff (!resetn)
      wr && idx == IDX_LOAD_RATIO |=> ratio_q == $past(pwdata);
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("load ratio write lost"); // RULE_11
  property p_ro_vel;
    @(posedge clk) disable iff (!resetn)
      wr && idx == IDX_INST_VEL && !vel_tick_q |=> $stable(inst_vel);
  endproperty
  a_ro_vel: assert property (p_ro_vel) else $error("velocity register written"); // RULE_14

  // bus side: ready is a single pulse, errors ride on it, writes wait for it
  property p_ready_pulse;
    @(posedge clk) disable iff (!resetn) pready_q |=> !pready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long"); // RULE_14
  property p_err_ready;
    @(posedge clk) disable iff (!resetn) pslverr_q |-> pready_q;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready"); // RULE_14
  property p_unmapped_err;
    @(posedge clk) disable iff (!resetn)
      psel && penable && !pready_q && !mapped(idx) |=> pslverr_q;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("no slave error"); // RULE_14
  property p_early_wr;
    @(posedge clk) disable iff (!resetn)
      psel && penable && !pready_q && idx == IDX_ACCEL |=> $stable(accel_q);
  endproperty
  a_early_wr: assert property (p_early_wr) else $error("write before ready"); // RULE_01
  property p_rdata_hold;
    @(posedge clk) disable iff (!resetn) psel && penable |=> $stable(prdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RULE_14

  // position path: refresh adds the encoder delta, relative update adds to both
  property p_refresh;
    @(posedge clk) disable iff (!resetn)
      tick_q && !wr && !ctrl_q[CTRL_GO_BIT] && !zero_event.valid
      |=> apos_q == $past(apos_q) + $past(encoder_count) - $past(enc_q);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh step wrong"); // RULE_05
  property p_rel_update;
    @(posedge clk) disable iff (!resetn)
      ctrl_q[CTRL_GO_BIT] && ctrl_q[CTRL_REL_BIT] && !tick_q && !wr && !zero_event.valid
      |=> apos_q == $past(apos_q) + $past(newp_q) && tgt_q == $past(tgt_q) + $past(newp_q);
  endproperty
  a_rel_update: assert property (p_rel_update) else $error("relative update split"); // RULE_13
  property p_go_clear;
    @(posedge clk) disable iff (!resetn)
      ctrl_q[CTRL_GO_BIT] && !(wr && idx == IDX_CTRL) |=> !ctrl_q[CTRL_GO_BIT];
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go bit stuck"); // RULE_13
  property p_delta;
    @(posedge clk) disable iff (!resetn)
      tick_q |=> delta_q == $past(encoder_count) - $past(enc_q);
  endproperty
  a_delta: assert property (p_delta) else $error("velocity delta wrong"); // RULE_10

  // accel and load ratio move only when written; averaged velocity ignores writes
  property p_avg_ro;
    @(posedge clk) disable iff (!resetn)
      wr && idx == IDX_AVG_VEL && !vel_tick_q |=> $stable(avg_vel);
  endproperty
  a_avg_ro: assert property (p_avg_ro) else $error("averaged velocity written"); // RULE_14
  property p_ratio_hold;
    @(posedge clk) disable iff (!resetn)
      !(wr && idx == IDX_LOAD_RATIO) |=> $stable(ratio_q);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("load ratio moved"); // RULE_11
  property p_accel_hold;
    @(posedge clk) disable iff (!resetn)
      !(wr && idx == IDX_ACCEL) |=> $stable(accel_q);
  endproperty
  a_accel_hold: assert property (p_accel_hold) else $error("accel moved"); // RULE_01
endmodule // motion_param_regs

// >>> verilog/motion_regs_pkg.sv
// package for the motion parameter register bank
// What this block does
// RULE_01: acceleration register holds counts per sample squared, reset 18.
// RULE_02: torque limit accepts 0..1023, reset 1023, caps drive torque.
// RULE_03: torque 1023 means 300 percent, 341 means 100 percent, linear.
// RULE_04: after zero search, index offset takes the single-turn zero position.
// RULE_05: actual position refreshes every 1.3 ms, or 2.6 ms with divider 2.
// RULE_06: actual position is a signed incremental counter; host write sets new base.
// RULE_07: host changes actual and target position atomically when drive not passive.
// RULE_08: device overwrites actual position when a zero search finishes.
// RULE_09: averaged velocity is read-only, measured over 16 samples, resets to 0.
// RULE_10: instantaneous velocity is read-only, counts per sample, resets to 0.
// RULE_11: load ratio is 16.16 fixed point, reset 65536 meaning 1.0.
// RULE_12: host sets load ratio 1.0 unloaded, before tuning filters.
// RULE_13: atomic new-position updates actual and target together, absolute or relative.
// RULE_14: all registers 32 bits; writes to velocity registers are ignored.
package motion_regs_pkg;
  localparam int          CLK_HZ           = 40000000;
  localparam int          PERIOD_US        = 1300;
  localparam int          PERIOD_CYC       = PERIOD_US * (CLK_HZ / 1000000);
  localparam logic [7:0]  IDX_ACCEL        = 8'h06;
  localparam logic [7:0]  IDX_TORQUE       = 8'h07;
  localparam logic [7:0]  IDX_FUNC_POS     = 8'h08;
  localparam logic [7:0]  IDX_ZERO_OFS     = 8'h09;
  localparam logic [7:0]  IDX_ACT_POS      = 8'h0A;
  localparam logic [7:0]  IDX_AVG_VEL      = 8'h0B;
  localparam logic [7:0]  IDX_INST_VEL     = 8'h0C;
  localparam logic [7:0]  IDX_LOAD_RATIO   = 8'h0D;
  localparam logic [7:0]  IDX_NEW_POS      = 8'h20;
  localparam logic [7:0]  IDX_CTRL         = 8'h21;
  localparam logic [7:0]  IDX_TARGET_POS   = 8'h22;
  localparam int          CTRL_DIV2_BIT    = 0;
  localparam int          CTRL_REL_BIT     = 1;
  localparam int          CTRL_GO_BIT      = 2;
  localparam logic [31:0] RST_ACCEL        = 32'h0000_0012;
  localparam logic [31:0] RST_TORQUE       = 32'h0000_03FF;
  localparam logic [31:0] TORQUE_MAX       = 32'h0000_03FF;
  localparam logic [31:0] RST_LOAD_RATIO   = 32'h0001_0000;
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  localparam int          AVG_SHIFT        = 4;
  typedef struct packed {
    logic        valid;
    logic [31:0] position;
    logic [31:0] single_turn;
  } zero_event_t;
endpackage

// >>> verilog/velocity_sampler.sv
// sampling of position into instantaneous and 16-sample averaged velocity
`timescale 1ns/1ps
module velocity_sampler
  import motion_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sample,
  input  wire logic [31:0] delta,
  output logic      [31:0] inst_vel,
  output logic      [31:0] avg_vel
);
  logic [31:0] hist_q [16];
  logic [31:0] hist_d [16];
  logic [35:0] sum_q, sum_d;
  logic [31:0] inst_q, inst_d, avg_q, avg_d;

  always_comb begin
    hist_d = hist_q;
    sum_d  = sum_q;
    inst_d = inst_q;
    avg_d  = avg_q;
    if (sample) begin
      // running sum keeps the average to one add and one subtract per sample
      sum_d  = sum_q + {{4{delta[31]}}, delta} - {{4{hist_q[15][31]}}, hist_q[15]}; // RULE_09
      for (int i = 15; i > 0; i--) hist_d[i] = hist_q[i-1];
      hist_d[0] = delta;
      inst_d = delta; // RULE_10
      avg_d  = sum_d[35:AVG_SHIFT]; // RULE_09
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) hist_q[i] <= RST_ZERO;
      sum_q  <= '0;
      inst_q <= RST_ZERO;
      avg_q  <= RST_ZERO;
    end else begin
      hist_q <= hist_d;
      sum_q  <= sum_d;
      inst_q <= inst_d;
      avg_q  <= avg_d;
    end
  end

  assign inst_vel = inst_q;
  assign avg_vel  = avg_q;

  property p_inst_follows;
    @(posedge clk) disable iff (!resetn) sample |=> inst_q == $past(delta);
  endproperty
  a_inst_follows: assert property (p_inst_follows) else $error("inst vel not sampled"); // RULE_10
  property p_avg_hold;
    @(posedge clk) disable iff (!resetn) !sample |=> $stable(avg_q);
  endproperty
  a_avg_hold: assert property (p_avg_hold) else $error("avg vel moved off sample"); // RULE_09
endmodule // velocity_sampler
